/* File: rtl/ccr_cfg.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  converter configuration register bank.
  Assumes it is included by bare name from the rtl folder.
*/
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// Register offsets
`define CCR_OFS_SETPOINT 8'h00
`define CCR_OFS_MAIN     8'h01
`define CCR_OFS_RANGE    8'h02
`define CCR_OFS_AUX      8'h03

// Main config field positions
`define CCR_MAIN_RESET  7
`define CCR_MAIN_SSC    6
`define CCR_MAIN_SOFT_SWITCH_ENABLE   5
`define CCR_MAIN_FPWM   4
`define CCR_MAIN_DISCH  3
`define CCR_MAIN_HICCUP 2

// Range and aux field positions
`define CCR_RANGE_LSB 2
`define CCR_AUX_SINGLE 1
`define CCR_AUX_PGBLANK 0

// Reset values
`define CCR_MAIN_RST   7'h2a
`define CCR_SOFTSTART_DURATION_RST 2'h1
`define CCR_AUX_RST    2'h0

// Setpoint arithmetic, microvolts
`define CCR_BASE_LOW_UV  400000
`define CCR_BASE_HIGH_UV 800000
`define CCR_STEP1_UV     1250
`define CCR_STEP2_UV     2500
`define CCR_STEP3_UV     5000
`define CCR_STEP4_UV     10000

// Slew rates, microvolts per microsecond
`define CCR_SLEW0_UV 10000
`define CCR_SLEW1_UV 5000
`define CCR_SLEW2_UV 1250
`define CCR_SLEW3_UV 500

// Timing at the core clock
`define CCR_CLK_HZ     10000000
`define CCR_US_CYC     (`CCR_CLK_HZ / 1000000)
`define CCR_SS_MIN_US  500
`define CCR_SS_MIN_CYC (`CCR_SS_MIN_US * `CCR_US_CYC)

`endif

/* File: rtl/ccr_pkg.sv */
/*
  Types shared by the converter configuration register bank.
  Assumes nothing of its surroundings.
*/
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_ST_INIT  = 2'b01,
    CCR_ST_READY = 2'b10
  } ccr_state_t;

  typedef enum logic [1:0] {
    CCR_RNG_1 = 2'b00,
    CCR_RNG_2 = 2'b01,
    CCR_RNG_3 = 2'b10,
    CCR_RNG_4 = 2'b11
  } ccr_range_t;

  typedef logic [21:0] ccr_uv_t;
endpackage : ccr_pkg

/* File: rtl/ccr_strap_decode.sv */
/*
  Decodes the strap select pins into a setpoint code and range.
  Assumes the pins are static and sampled by the caller.
*/
`timescale 1ns/1ps

module ccr_strap_decode #(
  parameter int                         STRAP_W     = 3,
  parameter logic [(10<<STRAP_W)-1:0]   STRAP_TABLE = '0
) (
  // Pins
  input  wire logic [STRAP_W-1:0]       strapSelectPins,
  // Decoded defaults
  output      logic [7:0]               strapCode,
  output      ccr_pkg::ccr_range_t      strapRange
);
  import ccr_pkg::*;

  logic [9:0] entry;

  if (STRAP_W < 1 || STRAP_W > 4) begin : g_chk
    $error("strap width out of range");
  end

  // Entry is {range, code}
  assign entry      = STRAP_TABLE[10*strapSelectPins +: 10];
  assign strapCode  = entry[7:0];
  assign strapRange = ccr_range_t'(entry[9:8]);
endmodule : ccr_strap_decode

/* File: rtl/ccr_setpoint_calc.sv */
/*
  Converts setpoint code and range into a target voltage in microvolts.
  Assumes one core clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "ccr_cfg.svh"

module ccr_setpoint_calc (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // Setpoint fields
  input  wire logic [7:0]           code,
  input  wire ccr_pkg::ccr_range_t  range,
  // Result
  output      ccr_pkg::ccr_uv_t     setpointUv
);
  import ccr_pkg::*;

  ccr_uv_t base;
  ccr_uv_t step;
  ccr_uv_t next_setpointUv;

  always_comb begin
    unique case (range)
      CCR_RNG_1: begin
        base = 22'(`CCR_BASE_LOW_UV);
        step = 22'(`CCR_STEP1_UV);
      end
      CCR_RNG_2: begin
        base = 22'(`CCR_BASE_LOW_UV);
        step = 22'(`CCR_STEP2_UV);
      end
      CCR_RNG_3: begin
        base = 22'(`CCR_BASE_LOW_UV);
        step = 22'(`CCR_STEP3_UV);
      end
      CCR_RNG_4: begin
        base = 22'(`CCR_BASE_HIGH_UV);
        step = 22'(`CCR_STEP4_UV);
      end
    endcase
    next_setpointUv = base + ({14'h0, code} * step);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      setpointUv <= '0;
    end else begin
      setpointUv <= next_setpointUv;
    end
  end
endmodule : ccr_setpoint_calc

/* File: rtl/ccr_config_regs.sv */
/*
  Configuration register bank of a step-down converter: setpoint,
  main config, range/soft-start and aux registers, plus the control
  outputs that these steer.
  Assumes an I2C target engine in front that presents the register
  address and data and pulses regWrAck on the falling edge of the
  acknowledge after the data byte; all pins synchronous to clock.
*/
// ------------------------------------------------------------------
// Operation
// ------------------------------------------------------------------
// Operation
// - Ranges 1-3: setpoint is 0.4 V plus code times 1.25/2.5/5 mV.
// - Range 4: setpoint is 0.8 V plus code times 10 mV.
// - Setpoint and range defaults come from straps sampled at start-up.
// - Main config resets to 0x2a.
// - Writing 1 to main bit 7 resets all and restarts init; reads 0.
// - Main bit 6 enables spread-spectrum clocking.
// - Main bit 5 gates switching; setting it while the enable pin is high skips the pin delay.
// - Main bit 4 forces PWM, ORed with the mode/sync pin.
// - Main bit 3 enables active output discharge.
// - Main bits 1-0 pick ramp speed 10, 5, 1.25 or 0.5 mV/us.
// - Range bits 7-4 reserved, read zero; controller writes zero.
// - Range bits 3-2 pick the setpoint span.
// - Range bits 1-0 pick soft-start 0.5, 1, 2 or 4 ms; default 1 ms.
// - Aux config resets to zero.
// - A write takes effect at the acknowledge falling edge.
// - Unmapped addresses read zero.
`timescale 1ns/1ps
`include "ccr_cfg.svh"

module ccr_config_regs #(
  parameter int                        INIT_CYCLES     = 16,
  parameter int                        EN_DELAY_CYCLES = 16,
  parameter int                        SS_MIN_CYCLES   = `CCR_SS_MIN_CYC,
  parameter int                        SYNC_WINDOW     = 32,
  parameter int                        STRAP_W         = 3,
  parameter logic [(10<<STRAP_W)-1:0]  STRAP_TABLE     = '0
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Register port from the I2C target engine
  input  wire logic [7:0]              regWrAddr,
  input  wire logic [7:0]              regWrData,
  input  wire logic                    regWrAck,
  input  wire logic [7:0]              regRdAddr,
  output      logic [7:0]              regRdData,
  output      logic                    regBusy,
  // Pins
  input  wire logic [STRAP_W-1:0]      strapSelectPins,
  input  wire logic                    enablePin,
  input  wire logic                    modeSyncPin,
  // Converter controls
  output      ccr_pkg::ccr_uv_t        targetSetpointUv,
  output      ccr_pkg::ccr_uv_t        rampSetpointUv,
  output      logic [13:0]             slewRateUvPerUs,
  output      logic                    spreadClockEnable,
  output      logic                    switchingActive,
  output      logic                    softstartActive,
  output      logic                    forcedPwmActive,
  output      logic                    outputDischargeEnable,
  output      logic                    hiccupProtectEnable,
  output      logic [1:0]              auxConfigBits
);
  import ccr_pkg::*;

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_chk_init
    $error("INIT_CYCLES out of range");
  end
  if (EN_DELAY_CYCLES < 1 || EN_DELAY_CYCLES > 65535) begin : g_chk_en
    $error("EN_DELAY_CYCLES out of range");
  end
  if (SS_MIN_CYCLES < 1 || SS_MIN_CYCLES > 8191) begin : g_chk_ss
    $error("SS_MIN_CYCLES out of range");
  end
  if (SYNC_WINDOW < 1 || SYNC_WINDOW > 65535) begin : g_chk_sync
    $error("SYNC_WINDOW out of range");
  end

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  ccr_state_t  state;
  logic [15:0] initCnt;
  logic [7:0]  outputSetpointCode;
  logic [6:0]  mainConfig;
  ccr_range_t  setpointRangeSelect;
  logic [1:0]  softstartDuration;
  logic [1:0]  auxConfig;
  logic [7:0]  strapCode;
  ccr_range_t  strapRange;
  logic        wrTaken;
  logic        softReset;
  logic        initDone;
  logic        swenRise;
  logic [15:0] enDelayCnt;
  logic        pinQualified;
  logic        switchPrev;
  logic [15:0] ssCnt;
  logic [15:0] ssLimit;
  logic        syncPrev;
  logic [15:0] syncHold;
  logic [3:0]  usCnt;
  logic        usTick;
  ccr_uv_t     rampDiff;

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  // Commit on ack edge
  assign wrTaken   = regWrAck && (state == CCR_ST_READY);
  assign softReset = wrTaken && (regWrAddr == `CCR_OFS_MAIN)
                     && regWrData[`CCR_MAIN_RESET];
  assign initDone  = (state == CCR_ST_INIT)
                     && (initCnt == 16'(INIT_CYCLES - 1));
  assign swenRise  = wrTaken && !softReset
                     && (regWrAddr == `CCR_OFS_MAIN)
                     && regWrData[`CCR_MAIN_SOFT_SWITCH_ENABLE]
                     && !mainConfig[`CCR_MAIN_SOFT_SWITCH_ENABLE];
  assign regBusy   = (state == CCR_ST_INIT);

  // ------------------------------------------------------------------
  // Initialization sequence
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state   <= CCR_ST_INIT;
      initCnt <= '0;
    end else begin
      unique case (state)
        CCR_ST_INIT: begin
          initCnt <= initCnt + 16'h0001;
          if (initDone) begin
            state <= CCR_ST_READY;
          end
        end
        CCR_ST_READY: begin
          initCnt <= '0;
          if (softReset) begin
            state <= CCR_ST_INIT;
          end
        end
        default: begin
          state   <= CCR_ST_INIT;
          initCnt <= '0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Strap defaults
  // ------------------------------------------------------------------
  ccr_strap_decode #(
    .STRAP_W     (STRAP_W),
    .STRAP_TABLE (STRAP_TABLE)
  ) u_strap (
    .strapSelectPins (strapSelectPins),
    .strapCode       (strapCode),
    .strapRange      (strapRange)
  );

  // ------------------------------------------------------------------
  // Setpoint and range registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      outputSetpointCode  <= '0;
      setpointRangeSelect <= CCR_RNG_1;
    end else if (softReset) begin
      outputSetpointCode  <= '0;
      setpointRangeSelect <= CCR_RNG_1;
    end else if (initDone) begin
      outputSetpointCode  <= strapCode;
      setpointRangeSelect <= strapRange;
    end else if (wrTaken) begin
      if (regWrAddr == `CCR_OFS_SETPOINT) begin
        outputSetpointCode <= regWrData;
      end
      if (regWrAddr == `CCR_OFS_RANGE) begin
        setpointRangeSelect <= ccr_range_t'(regWrData[`CCR_RANGE_LSB +: 2]);
      end
    end
  end

  // ------------------------------------------------------------------
  // Main, soft-start and aux registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mainConfig        <= `CCR_MAIN_RST;
      softstartDuration <= `CCR_SOFTSTART_DURATION_RST;
      auxConfig         <= `CCR_AUX_RST;
    end else if (softReset) begin
      mainConfig        <= `CCR_MAIN_RST;
      softstartDuration <= `CCR_SOFTSTART_DURATION_RST;
      auxConfig         <= `CCR_AUX_RST;
    end else if (wrTaken) begin
      if (regWrAddr == `CCR_OFS_MAIN) begin
        mainConfig <= regWrData[6:0];
      end
      if (regWrAddr == `CCR_OFS_RANGE) begin
        softstartDuration <= regWrData[1:0];
      end
      if (regWrAddr == `CCR_OFS_AUX) begin
        auxConfig <= regWrData[1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdData <= '0;
    end else begin
      unique case (regRdAddr)
        `CCR_OFS_SETPOINT: regRdData <= outputSetpointCode;
        `CCR_OFS_MAIN:     regRdData <= {1'b0, mainConfig};
        `CCR_OFS_RANGE:    regRdData <= {4'h0, setpointRangeSelect,
                                         softstartDuration};
        `CCR_OFS_AUX:      regRdData <= {6'h00, auxConfig};
        default:           regRdData <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Static control outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      spreadClockEnable     <= 1'b0;
      outputDischargeEnable <= 1'b0;
      hiccupProtectEnable   <= 1'b0;
      auxConfigBits         <= '0;
      slewRateUvPerUs       <= '0;
    end else begin
      spreadClockEnable     <= mainConfig[`CCR_MAIN_SSC];
      outputDischargeEnable <= mainConfig[`CCR_MAIN_DISCH];
      hiccupProtectEnable   <= mainConfig[`CCR_MAIN_HICCUP];
      auxConfigBits         <= auxConfig;
      unique case (mainConfig[1:0])
        2'h0: slewRateUvPerUs <= 14'(`CCR_SLEW0_UV);
        2'h1: slewRateUvPerUs <= 14'(`CCR_SLEW1_UV);
        2'h2: slewRateUvPerUs <= 14'(`CCR_SLEW2_UV);
        2'h3: slewRateUvPerUs <= 14'(`CCR_SLEW3_UV);
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Forced PWM with mode/sync pin
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      syncPrev <= 1'b0;
      syncHold <= '0;
    end else begin
      syncPrev <= modeSyncPin;
      if (modeSyncPin != syncPrev) begin
        syncHold <= 16'(SYNC_WINDOW);
      end else if (syncHold != 16'h0000) begin
        syncHold <= syncHold - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      forcedPwmActive <= 1'b0;
    end else begin
      forcedPwmActive <= mainConfig[`CCR_MAIN_FPWM] | modeSyncPin
                         | (syncHold != 16'h0000);
    end
  end

  // ------------------------------------------------------------------
  // Switching enable
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      enDelayCnt   <= '0;
      pinQualified <= 1'b0;
    end else if (!enablePin || softReset) begin
      enDelayCnt   <= '0;
      pinQualified <= 1'b0;
    end else if (swenRise) begin
      pinQualified <= 1'b1;
    end else if (!pinQualified) begin
      if (enDelayCnt == 16'(EN_DELAY_CYCLES - 1)) begin
        pinQualified <= 1'b1;
      end else begin
        enDelayCnt <= enDelayCnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      switchingActive <= 1'b0;
      switchPrev      <= 1'b0;
    end else begin
      switchingActive <= (state == CCR_ST_READY) && enablePin
                         && pinQualified && mainConfig[`CCR_MAIN_SOFT_SWITCH_ENABLE];
      switchPrev      <= switchingActive;
    end
  end

  // ------------------------------------------------------------------
  // Soft-start timer
  // ------------------------------------------------------------------
  // Duration doubles per code
  assign ssLimit = 16'(SS_MIN_CYCLES) << softstartDuration;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ssCnt           <= '0;
      softstartActive <= 1'b0;
    end else if (!switchingActive) begin
      ssCnt           <= '0;
      softstartActive <= 1'b0;
    end else if (!switchPrev) begin
      ssCnt           <= 16'h0001;
      softstartActive <= 1'b1;
    end else if (softstartActive) begin
      if (ssCnt >= ssLimit) begin
        softstartActive <= 1'b0;
      end else begin
        ssCnt <= ssCnt + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // Target setpoint and voltage ramp
  // ------------------------------------------------------------------
  ccr_setpoint_calc u_calc (
    .clock      (clock),
    .nrst       (nrst),
    .code       (outputSetpointCode),
    .range      (setpointRangeSelect),
    .setpointUv (targetSetpointUv)
  );

  assign usTick = (usCnt == 4'(`CCR_US_CYC - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      usCnt <= '0;
    end else if (usTick) begin
      usCnt <= '0;
    end else begin
      usCnt <= usCnt + 4'h1;
    end
  end

  assign rampDiff = (rampSetpointUv > targetSetpointUv)
                    ? rampSetpointUv - targetSetpointUv
                    : targetSetpointUv - rampSetpointUv;

  // Ramp jumps at soft-start, then slews once per microsecond
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rampSetpointUv <= '0;
    end else if (!switchingActive) begin
      rampSetpointUv <= '0;
    end else if (!switchPrev || softstartActive) begin
      rampSetpointUv <= targetSetpointUv;
    end else if (usTick) begin
      if (rampDiff <= {8'h00, slewRateUvPerUs}) begin
        rampSetpointUv <= targetSetpointUv;
      end else if (rampSetpointUv < targetSetpointUv) begin
        rampSetpointUv <= rampSetpointUv + {8'h00, slewRateUvPerUs};
      end else begin
        rampSetpointUv <= rampSetpointUv - {8'h00, slewRateUvPerUs};
      end
    end
  end
endmodule : ccr_config_regs

/* File: dv/ccr_config_regs_sva.sv */
/*
  Port checker of the converter configuration register bank.
  Assumes it is bound onto ccr_config_regs and sees its ports only.
*/
`timescale 1ns/1ps

module ccr_config_regs_sva (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Register port
  input wire logic [7:0]  regWrAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrAck,
  input wire logic [7:0]  regRdAddr,
  input wire logic [7:0]  regRdData,
  input wire logic        regBusy,
  // Pins
  input wire logic        enablePin,
  input wire logic        modeSyncPin,
  // Controls
  input wire logic [13:0] slewRateUvPerUs,
  input wire logic        spreadClockEnable,
  input wire logic        switchingActive,
  input wire logic        forcedPwmActive,
  input wire logic        outputDischargeEnable,
  input wire logic        hiccupProtectEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  wire mainWr = regWrAck && !regBusy && regWrAddr == 8'h01 && !regWrData[7];
  wire softRst = regWrAck && !regBusy && regWrAddr == 8'h01 && regWrData[7];

  function automatic logic [13:0] slewOf(input logic [1:0] c);
    return c == 2'h0 ? 14'h2710 : c == 2'h1 ? 14'h1388 : c == 2'h2 ? 14'h04e2 : 14'h01f4;
  endfunction : slewOf

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  chk_rd_unmapped: assert property (regRdAddr > 8'h03 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_rd_reserved: assert property (regRdAddr == 8'h02 |=> regRdData[7:4] == 4'h0)
    else $error("range reserved bits not zero");
  chk_rd_resetbit: assert property (regRdAddr == 8'h01 |=> !regRdData[7])
    else $error("main bit 7 reads one");
  chk_main_default: assert property ($rose(nrst) && regRdAddr == 8'h01 |=> regRdData == 8'h2a)
    else $error("main default wrong");
  chk_main_fields: assert property (mainWr |=> ##1
    {spreadClockEnable, outputDischargeEnable, hiccupProtectEnable} ==
    {$past(regWrData[6], 2), $past(regWrData[3], 2), $past(regWrData[2], 2)})
    else $error("main fields not applied");
  chk_slew_decode: assert property (mainWr |=> ##1 slewRateUvPerUs == slewOf($past(regWrData[1:0], 2)))
    else $error("slew rate decode wrong");
  chk_pwm_pin: assert property (!regBusy && modeSyncPin |=> forcedPwmActive)
    else $error("mode pin does not force pwm");
  chk_sw_pin: assert property (!enablePin |=> !switchingActive)
    else $error("switching without enable pin");
  chk_sw_clear: assert property (mainWr && !regWrData[5] |=> ##1 !switchingActive)
    else $error("switching after enable bit cleared");
  chk_soft_reset: assert property (softRst |=> ##1 regBusy)
    else $error("soft reset did not restart init");

  cover property (mainWr);
  cover property (softRst);
  cover property ($rose(switchingActive));
endmodule : ccr_config_regs_sva

bind ccr_config_regs ccr_config_regs_sva chk (.clock(clock), .nrst(nrst),
  .regWrAddr(regWrAddr), .regWrData(regWrData), .regWrAck(regWrAck), .regRdAddr(regRdAddr),
  .regRdData(regRdData), .regBusy(regBusy), .enablePin(enablePin), .modeSyncPin(modeSyncPin),
  .slewRateUvPerUs(slewRateUvPerUs), .spreadClockEnable(spreadClockEnable),
  .switchingActive(switchingActive), .forcedPwmActive(forcedPwmActive),
  .outputDischargeEnable(outputDischargeEnable), .hiccupProtectEnable(hiccupProtectEnable));

/* File: dv/ccr_i2c_ctrl_model.sv */
/*
  Bus controller model: delivers register writes and reads as the
  target engine would hand them over.
  Assumes one clock shared with the register bank.
*/
`timescale 1ns/1ps

module ccr_i2c_ctrl_model (
  // Clock and read data
  input  wire logic  clock,
  input  wire logic  [7:0] regRdData,
  // Register port
  output logic [7:0] regWrAddr,
  output logic [7:0] regWrData,
  output logic       regWrAck,
  output logic [7:0] regRdAddr
);
  initial begin
    regWrAddr = 8'h01;
    regWrData = 8'h00;
    regWrAck = 1'b0;
    regRdAddr = 8'h01;
  end

  // standalone converter, hiccup may be set
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    regWrAddr = a;
    regWrData = d;
    regWrAck = 1'b1;
    @(posedge clock);
    #1;
    regWrAck = 1'b0;
    regWrData = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    regRdAddr = a;
    @(posedge clock);
    #1;
    d = regRdData;
  endtask : rd
endmodule : ccr_i2c_ctrl_model

/* File: dv/ccr_config_regs_tb_top.sv */
/*
  Testbench of the converter configuration register bank.
  Assumes the package, the checker and the controller model are compiled first.
*/
`timescale 1ns/1ps

module ccr_config_regs_tb_top;
  import ccr_pkg::*;
  // Strap entry 5 = range 10, code 0x40; entry 2 = range 11, code 0x12
  localparam logic [79:0] STRAPS = {20'h00000, 10'h240, 20'h0, 10'h312, 20'h0};
  logic [2:0] straps = 3'h5;
  logic       clock = 1'b0, nrst = 1'b0, enablePin = 1'b0, modeSyncPin = 1'b0;
  wire  [7:0] regWrAddr, regWrData, regRdAddr, regRdData;
  wire        regWrAck, regBusy, ssc, sw, ss, fpwm, dis, hic;
  wire  [1:0] aux;
  wire [13:0] slew;
  ccr_uv_t    target, ramp;
  logic [7:0] rv;
  int         miscompares = 0, nCompared = 0;
  logic [13:0] rates [4] = '{14'h2710, 14'h1388, 14'h04e2, 14'h01f4};

  always #50 clock = ~clock;

  ccr_config_regs #(.INIT_CYCLES(4), .EN_DELAY_CYCLES(4), .SS_MIN_CYCLES(20),
    .SYNC_WINDOW(8), .STRAP_TABLE(STRAPS)) dut (.clock(clock), .nrst(nrst),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .regWrAck(regWrAck), .regRdAddr(regRdAddr),
    .regRdData(regRdData), .regBusy(regBusy), .strapSelectPins(straps), .enablePin(enablePin),
    .modeSyncPin(modeSyncPin), .targetSetpointUv(target), .rampSetpointUv(ramp),
    .slewRateUvPerUs(slew), .spreadClockEnable(ssc), .switchingActive(sw),
    .softstartActive(ss), .forcedPwmActive(fpwm), .outputDischargeEnable(dis),
    .hiccupProtectEnable(hic), .auxConfigBits(aux));

  ccr_i2c_ctrl_model host (.clock(clock), .regRdData(regRdData), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .regWrAck(regWrAck), .regRdAddr(regRdAddr));

  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask : rdchk

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  task automatic ready;
    for (int k = 0; k < 100 && regBusy !== 1'b0; k++) settle(1);
    chk(regBusy, 1'b0);
  endtask : ready

  task automatic summarize;
    if (miscompares == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_defaults;
    rdchk(8'h00, 8'h40);
    rdchk(8'h02, 8'h09);
    rdchk(8'h01, 8'h2a);
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h00);
    rdchk(8'hff, 8'h00);
    chk(target, 22'h0afc80);
    chk(slew, 14'h04e2);
    chk({dis, ssc, hic, fpwm}, 4'h8);
  endtask : t_defaults

  task automatic t_main;
    host.wr(8'h01, 8'h5d);
    rdchk(8'h01, 8'h5d);
    chk({ssc, fpwm, dis, hic}, 4'hf);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h01, 8'(i));
      settle(2);
      chk(slew, rates[i]);
    end
    chk({ssc, fpwm, dis, hic}, 4'h0);
    modeSyncPin = 1'b1;
    settle(2);
    chk(fpwm, 1'b1);
    modeSyncPin = 1'b0;
  endtask : t_main

  task automatic t_range;
    for (int r = 0; r < 4; r++) begin
      host.wr(8'h02, {4'h0, 2'(r), 2'h1});
      host.wr(8'h00, 8'h80);
      settle(3);
      chk(target, r == 3 ? 22'h1fbd00 : 22'h061a80 + (22'h027100 << r));
    end
    host.wr(8'h02, 8'hfe);
    rdchk(8'h02, 8'h0e);
    host.wr(8'h03, 8'hff);
    rdchk(8'h03, 8'h03);
    chk(aux, 2'h3);
    host.wr(8'h07, 8'h55);
    rdchk(8'h07, 8'h00);
  endtask : t_range

  task automatic t_switch;
    int n;
    host.wr(8'h02, 8'h08);
    host.wr(8'h01, 8'h20);
    enablePin = 1'b1;
    settle(3);
    chk(sw, 1'b0);
    for (int k = 0; k < 20 && ss !== 1'b1; k++) settle(1);
    chk({sw, ss}, 2'h3);
    chk(ramp, 22'h0fde80);
    for (n = 0; n < 100 && ss === 1'b1; n++) settle(1);
    chk(n >= 19 && n <= 21, 1'b1);
    host.wr(8'h01, 8'h00);
    settle(2);
    chk(sw, 1'b0);
    chk(ramp, 22'h000000);
    rdchk(8'h00, 8'h80);
    enablePin = 1'b0;
    settle(2);
    enablePin = 1'b1;
    host.wr(8'h01, 8'h20);
    settle(2);
    chk(sw, 1'b1);
    enablePin = 1'b0;
  endtask : t_switch

  task automatic t_softreset;
    straps = 3'h2;
    host.wr(8'h01, 8'h80);
    settle(2);
    chk(regBusy, 1'b1);
    ready;
    rdchk(8'h01, 8'h2a);
    rdchk(8'h03, 8'h00);
    rdchk(8'h02, 8'h0d);
    rdchk(8'h00, 8'h12);
    chk(target, 22'h0ef420);
  endtask : t_softreset

  initial begin
    settle(10);
    nrst = 1'b1;
    ready;
    t_defaults;
    t_main;
    t_range;
    t_switch;
    t_softreset;
    summarize;
  end

  initial begin
    #(100 * 5000);
    miscompares++;
    summarize;
  end
endmodule : ccr_config_regs_tb_top
